// File: verilog/sdds_pkg.sv
// Shared constants for the sigma-delta decimation and rate converter block
package sdds_pkg;
  // Register offsets
  localparam logic [8:0] ADDR_BW  = 9'h00f;
  localparam logic [8:0] ADDR_FMT = 9'h014;
  localparam logic [8:0] ADDR_DCO = 9'h016;
  localparam logic [8:0] ADDR_DIV = 9'h101;
  // Field positions
  localparam int BW_LSB      = 5;
  localparam int FMT_LSB     = 0;
  localparam int SWING_BIT   = 7;
  localparam int DCO_INV_BIT = 7;
  localparam int DIV_LSB     = 0;
  // Reset values
  localparam logic [7:0] BW_RST  = 8'h00;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [7:0] DCO_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h08;
  // Divide code decode, factors kept in half steps
  localparam logic [5:0] DIV_SRC_RESET = 6'h00;
  localparam logic [5:0] DIV_MAX_FOUR  = 6'h08;
  localparam logic [6:0] KX2_FOUR      = 7'h08;
  localparam logic [6:0] KX2_STEP      = 7'h02;
  typedef enum logic [1:0] {FMT_OFFSET, FMT_TWOS, FMT_GRAY} sdds_fmt_t;
  // Datapath
  localparam int DW = 24;
  localparam int CW = 18;
  localparam logic [23:0] MOD_LEVEL = 24'h00_7fff;
  localparam int SINC_SH = 3;
  localparam int QUARTER_RATE_DECIMATOR_SH = 15;
  localparam int LPF_SH  = 16;
  localparam int FIRST_INTERPOLATOR_SH = 15;
  localparam int SECOND_INTERPOLATOR_SH = 13;
  // Coefficients, index 0 is the outer tap, last entry the centre
  localparam logic [1:0][17:0] SINC3_C = {18'sd3, 18'sd1};
  localparam logic [11:0][17:0] QUARTER_RATE_DECIMATOR_C = {
    18'sd16384, 18'sd10184, 18'sd0, -18'sd2796, 18'sd0, 18'sd1121,
    18'sd0, -18'sd418, 18'sd0, 18'sd122, 18'sd0, -18'sd21};
  localparam logic [31:0][17:0] LPF_C = {
    18'sd38956, 18'sd21141, -18'sd5305, -18'sd6870, 18'sd4051, 18'sd3022,
    -18'sd3326, -18'sd1147, 18'sd2612, 18'sd103, -18'sd1909, 18'sd450,
    18'sd1271, -18'sd677, -18'sd744, 18'sd694, 18'sd353, -18'sd592,
    -18'sd98, 18'sd441, -18'sd42, -18'sd291, 18'sd97, 18'sd170,
    -18'sd98, -18'sd84, 18'sd78, 18'sd36, -18'sd52, -18'sd15,
    18'sd31, 18'sd17};
  localparam logic [13:0][17:0] FIRST_INTERPOLATOR_C = {
    18'sd32768, 18'sd20433, 18'sd0, -18'sd5761, 18'sd0, 18'sd2450, 18'sd0,
    -18'sd1017, 18'sd0, 18'sd361, 18'sd0, -18'sd97, 18'sd0, 18'sd15};
  localparam logic [7:0][17:0] SECOND_INTERPOLATOR_C = {
    18'sd8192, 18'sd4928, 18'sd0, -18'sd1032, 18'sd0, 18'sd227, 18'sd0,
    -18'sd27};
endpackage

// File: verilog/sdds_fir.sv
// Symmetric FIR with optional decimation, one product per tap
`timescale 1ns/1ns
`default_nettype none
module sdds_fir #(
  parameter int NTAP  = 23,
  parameter int DECIM = 1,
  parameter int SHIFT = 15,
  parameter logic [((NTAP+1)/2)*18-1:0] COEF = '0
) (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_i,
  // Input samples
  input  wire logic                   in_valid_i,
  input  wire logic [sdds_pkg::DW-1:0] in_data_i,
  // Output samples
  output logic                        out_valid_o,
  output logic [sdds_pkg::DW-1:0]     out_data_o
);
  localparam int DW = sdds_pkg::DW;
  localparam int AW = DW + sdds_pkg::CW + $clog2(NTAP) + 1;

  typedef struct packed {
    logic [NTAP-1:0][DW-1:0] line;
    logic [7:0]              phase;
    logic                    valid;
    logic [DW-1:0]           data;
  } sdds_fir_t;

  sdds_fir_t         r_reg;
  sdds_fir_t         r_next;
  logic signed [AW-1:0] acc;

  generate
    if (NTAP < 2 || DECIM < 1 || DECIM > 255 || SHIFT >= AW) begin : g_bad
      $error("sdds_fir: unsupported tap count, decimation or shift");
    end
  endgenerate

  // Mirror index: only the outer half and the centre are stored
  function automatic logic signed [17:0] coef(input int k);
    int idx;
    idx = (k < NTAP - 1 - k) ? k : NTAP - 1 - k;
    coef = $signed(COEF[idx*18 +: 18]);
  endfunction

  always_comb begin
    r_next = r_reg;
    r_next.valid = 1'b0;
    acc = '0;
    if (in_valid_i) begin
      r_next.line = {r_reg.line[NTAP-2:0], in_data_i};
      for (int k = 0; k < NTAP; k++) begin
        acc = acc + $signed(r_next.line[k]) * coef(k);
      end
      if (r_reg.phase == 8'(DECIM - 1)) begin
        r_next.phase = '0;
        r_next.valid = 1'b1;
        r_next.data = DW'(acc >>> SHIFT);
      end else begin
        r_next.phase = r_reg.phase + 8'h01;
      end
    end
    if (reset_i) begin
      r_next = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    r_reg <= r_next;
  end

  assign out_valid_o = r_reg.valid;
  assign out_data_o  = r_reg.data;

  // An output only ever follows an accepted input sample
  a_out_follows_in: assert property (@(posedge core_clk_i) disable iff (reset_i)
    out_valid_o |-> $past(in_valid_i))
    else $error("fir output without input");
  // Decimation leaves DECIM-1 inputs without an output
  a_decim_gap: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (DECIM > 1 && out_valid_o) |-> !$past(out_valid_o))
    else $error("fir decimation spacing broken");
endmodule
`default_nettype wire

// File: verilog/sdds_engine.sv
// Decimation chain, rate converter and output formatter of the converter
`timescale 1ns/1ns
`default_nettype none
module sdds_engine (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // Modulator bitstream, one bit per clock
  input  wire logic        mod_bit_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [8:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic [7:0]       reg_rdata_o,
  // Output words
  input  wire logic        out_ready_i,
  output logic             word_valid_o,
  output logic [15:0]      data_o,
  output logic             data_clock_output_o,
  output logic             swing_full_o
);
  localparam int DW = sdds_pkg::DW;

  typedef struct packed {
    logic [1:0]       bw;
    logic [1:0]       fmt;
    logic             swing;
    logic             dco_inv;
    logic [5:0]       div;
    logic [7:0]       rdata;
    logic [1:0]       i1_pend;
    logic             i2_pend;
    logic [DW-1:0]    held;
    logic [6:0]       acc;
    logic             pend_v;
    logic [15:0]      pend_w;
    logic [1:0][15:0] fifo;
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
    logic [15:0]      data;
    logic             lvl;
    logic [6:0]       gap;
    logic             clean;
  } sdds_state_t;

  sdds_state_t   r_reg;
  sdds_state_t   r_next;

  logic          src_rst;
  logic          src_rst_q;
  logic [6:0]    kx2;
  logic [6:0]    acc_sum;
  logic          tick;
  logic          push;
  logic          pop;
  logic [15:0]   word_in;
  logic [15:0]   head;
  logic [2:0]    s_v;
  logic [2:0][DW-1:0] s_d;
  logic          dec_in_v;
  logic [DW-1:0] dec_in_d;
  logic          quarter_rate_decimator_v;
  logic [DW-1:0] quarter_rate_decimator_d;
  logic          lpf_v;
  logic [DW-1:0] lpf_d;
  logic          first_interpolator_v;
  logic [DW-1:0] first_interpolator_d;
  logic          second_interpolator_v;
  logic [DW-1:0] second_interpolator_d;

  // The bitstream enters as plus or minus full scale
  assign s_v[0] = 1'b1;
  assign s_d[0] = mod_bit_i ? sdds_pkg::MOD_LEVEL : -sdds_pkg::MOD_LEVEL;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sinc
      sdds_fir #(
        .NTAP  (4),
        .DECIM (2),
        .SHIFT (sdds_pkg::SINC_SH),
        .COEF  (sdds_pkg::SINC3_C)
      ) u_sinc (
        .core_clk_i  (core_clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (s_v[g]),
        .in_data_i   (s_d[g]),
        .out_valid_o (s_v[g+1]),
        .out_data_o  (s_d[g+1])
      );
    end
  endgenerate

  // Code 3 is treated like code 2
  always_comb begin
    case (r_reg.bw)
      2'b00: begin
        dec_in_v = s_v[0];
        dec_in_d = s_d[0];
      end
      2'b01: begin
        dec_in_v = s_v[1];
        dec_in_d = s_d[1];
      end
      default: begin
        dec_in_v = s_v[2];
        dec_in_d = s_d[2];
      end
    endcase
  end

  sdds_fir #(
    .NTAP  (23),
    .DECIM (4),
    .SHIFT (sdds_pkg::QUARTER_RATE_DECIMATOR_SH),
    .COEF  (sdds_pkg::QUARTER_RATE_DECIMATOR_C)
  ) u_quarter_rate_decimator (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (dec_in_v),
    .in_data_i   (dec_in_d),
    .out_valid_o (quarter_rate_decimator_v),
    .out_data_o  (quarter_rate_decimator_d)
  );

  sdds_fir #(
    .NTAP  (63),
    .DECIM (1),
    .SHIFT (sdds_pkg::LPF_SH),
    .COEF  (sdds_pkg::LPF_C)
  ) u_band_lowpass_equalizer (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (quarter_rate_decimator_v),
    .in_data_i   (quarter_rate_decimator_d),
    .out_valid_o (lpf_v),
    .out_data_o  (lpf_d)
  );

  // Zero stuffing: first stage two cycles late so second stage never collides
  sdds_fir #(
    .NTAP  (27),
    .DECIM (1),
    .SHIFT (sdds_pkg::FIRST_INTERPOLATOR_SH),
    .COEF  (sdds_pkg::FIRST_INTERPOLATOR_C)
  ) u_first_interpolator (
    .core_clk_i  (core_clk_i),
    .reset_i     (src_rst_q),
    .in_valid_i  (lpf_v | r_reg.i1_pend[1]),
    .in_data_i   (lpf_v ? lpf_d : '0),
    .out_valid_o (first_interpolator_v),
    .out_data_o  (first_interpolator_d)
  );

  sdds_fir #(
    .NTAP  (15),
    .DECIM (1),
    .SHIFT (sdds_pkg::SECOND_INTERPOLATOR_SH),
    .COEF  (sdds_pkg::SECOND_INTERPOLATOR_C)
  ) u_second_interpolator (
    .core_clk_i  (core_clk_i),
    .reset_i     (src_rst_q),
    .in_valid_i  (first_interpolator_v | r_reg.i2_pend),
    .in_data_i   (first_interpolator_v ? first_interpolator_d : '0),
    .out_valid_o (second_interpolator_v),
    .out_data_o  (second_interpolator_d)
  );

  function automatic logic [15:0] sat16(input logic [DW-1:0] x);
    if ($signed(x) > $signed(DW'(16'h7fff))) begin
      sat16 = 16'h7fff;
    end else if ($signed(x) < -$signed(DW'(16'h7fff)) - 1) begin
      sat16 = 16'h8000;
    end else begin
      sat16 = x[15:0];
    end
  endfunction

  function automatic logic [15:0] enc(input logic [1:0] f, input logic [15:0] w);
    logic [15:0] ob;
    ob = {~w[15], w[14:0]};
    case (f)
      sdds_pkg::FMT_TWOS: enc = w;
      sdds_pkg::FMT_GRAY: enc = ob ^ (ob >> 1);
      default:            enc = ob;
    endcase
  endfunction

  assign src_rst   = reset_i || r_reg.div == sdds_pkg::DIV_SRC_RESET;
  assign kx2       = (r_reg.div <= sdds_pkg::DIV_MAX_FOUR) ? sdds_pkg::KX2_FOUR
                     : {1'b0, r_reg.div};
  assign acc_sum   = r_reg.acc + sdds_pkg::KX2_STEP;
  // A held word stalls the resampler rather than being overwritten
  assign tick      = !src_rst && !r_reg.pend_v && acc_sum >= kx2;
  assign word_in   = r_reg.pend_v ? r_reg.pend_w : sat16(r_reg.held);
  assign push      = (tick || r_reg.pend_v) && r_reg.cnt != 2'd2;
  assign head      = r_reg.fifo[r_reg.rp];
  assign pop       = r_reg.cnt != 2'd0 && out_ready_i && r_reg.lvl;

  always_ff @(posedge core_clk_i) begin
    src_rst_q <= src_rst;
  end

  always_comb begin
    r_next = r_reg;
    if (reg_wr_i) begin
      case (reg_addr_i)
        sdds_pkg::ADDR_BW:  r_next.bw = reg_wdata_i[sdds_pkg::BW_LSB +: 2];
        sdds_pkg::ADDR_FMT: begin
          r_next.fmt   = reg_wdata_i[sdds_pkg::FMT_LSB +: 2];
          r_next.swing = reg_wdata_i[sdds_pkg::SWING_BIT];
        end
        sdds_pkg::ADDR_DCO: r_next.dco_inv = reg_wdata_i[sdds_pkg::DCO_INV_BIT];
        sdds_pkg::ADDR_DIV: r_next.div = reg_wdata_i[sdds_pkg::DIV_LSB +: 6];
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        sdds_pkg::ADDR_BW:  r_next.rdata = 8'(r_reg.bw) << sdds_pkg::BW_LSB;
        sdds_pkg::ADDR_FMT: r_next.rdata = (8'(r_reg.fmt) << sdds_pkg::FMT_LSB)
                            | (8'(r_reg.swing) << sdds_pkg::SWING_BIT);
        sdds_pkg::ADDR_DCO: r_next.rdata = 8'(r_reg.dco_inv) << sdds_pkg::DCO_INV_BIT;
        sdds_pkg::ADDR_DIV: r_next.rdata = 8'(r_reg.div) << sdds_pkg::DIV_LSB;
        default:            r_next.rdata = 8'h00;
      endcase
    end
    // Interpolator zero stuffing
    r_next.i1_pend = {r_reg.i1_pend[0], lpf_v};
    r_next.i2_pend = first_interpolator_v;
    if (second_interpolator_v) begin
      r_next.held = second_interpolator_d;
    end
    // Resampler phase in half steps of the modulator clock
    if (!r_reg.pend_v) begin
      r_next.acc = tick ? acc_sum - kx2 : acc_sum;
    end
    if (tick && !push) begin
      r_next.pend_v = 1'b1;
      r_next.pend_w = word_in;
    end else if (r_reg.pend_v && push) begin
      r_next.pend_v = 1'b0;
    end
    if (push) begin
      r_next.fifo[r_reg.wp] = word_in;
      r_next.wp = ~r_reg.wp;
    end
    if (pop) begin
      r_next.rp = ~r_reg.rp;
    end
    r_next.cnt = r_reg.cnt + 2'(push) - 2'(pop);
    // Data changes with the clock low; its rising edge follows one cycle later
    if (pop) begin
      r_next.data = enc(r_reg.fmt, head);
      r_next.lvl  = 1'b0;
    end else begin
      r_next.lvl  = 1'b1;
    end
    // Cycle spacing of ticks, used only by the checks below
    r_next.gap   = tick ? 7'h01 : r_reg.gap + 7'h01;
    r_next.clean = tick ? 1'b1 : r_reg.clean && !r_reg.pend_v;
    if (src_rst) begin
      r_next.i1_pend = '0;
      r_next.i2_pend = 1'b0;
      r_next.held    = '0;
      r_next.acc     = '0;
      r_next.pend_v  = 1'b0;
      r_next.wp      = 1'b0;
      r_next.rp      = 1'b0;
      r_next.cnt     = '0;
      r_next.clean   = 1'b0;
    end
    if (reset_i) begin
      r_next         = '0;
      r_next.bw      = sdds_pkg::BW_RST[sdds_pkg::BW_LSB +: 2];
      r_next.fmt     = sdds_pkg::FMT_RST[sdds_pkg::FMT_LSB +: 2];
      r_next.swing   = sdds_pkg::FMT_RST[sdds_pkg::SWING_BIT];
      r_next.dco_inv = sdds_pkg::DCO_RST[sdds_pkg::DCO_INV_BIT];
      r_next.div     = sdds_pkg::DIV_RST[sdds_pkg::DIV_LSB +: 6];
      r_next.lvl     = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    r_reg <= r_next;
  end

  assign reg_rdata_o         = r_reg.rdata;
  assign word_valid_o        = r_reg.cnt != 2'd0;
  assign data_o              = r_reg.data;
  assign data_clock_output_o = r_reg.lvl ^ r_reg.dco_inv;
  assign swing_full_o        = r_reg.swing;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_tick_spacing: assert property (tick |=> !tick [*3])
    else $error("output ticks closer than four cycles");
  a_tick_period: assert property (
    tick && r_reg.clean && !$past(src_rst) |->
      r_reg.gap == kx2[6:1] || (kx2[0] && r_reg.gap == kx2[6:1] + 7'h01))
    else $error("output tick period does not match divide factor");
  a_src_reset: assert property (
    r_reg.div == sdds_pkg::DIV_SRC_RESET |=> r_reg.cnt == 2'd0 && !tick)
    else $error("rate converter ran while held in reset");
  a_fmt_offset: assert property (
    pop && r_reg.fmt == 2'b00 |=> data_o == {~$past(head[15]), $past(head[14:0])})
    else $error("offset binary word wrong");
  a_fmt_twos: assert property (
    pop && r_reg.fmt == 2'b01 |=> data_o == $past(head))
    else $error("twos complement word wrong");
  a_fmt_gray: assert property (
    pop && r_reg.fmt == 2'b10 |=> data_o == ({~$past(head[15]), $past(head[14:0])}
      ^ ({~$past(head[15]), $past(head[14:0])} >> 1)))
    else $error("gray word wrong");
  a_dco_edge: assert property (
    // Compared against the live invert bit, so a write in flight cannot confuse it
    pop |=> data_clock_output_o == r_reg.dco_inv ##1 data_clock_output_o != r_reg.dco_inv)
    else $error("data clock edge misplaced");
  a_data_hold: assert property ($changed(data_o) |-> $past(pop))
    else $error("data changed without a word");
  a_swing_write: assert property (
    reg_wr_i && reg_addr_i == sdds_pkg::ADDR_FMT
    |=> swing_full_o == $past(reg_wdata_i[sdds_pkg::SWING_BIT]))
    else $error("swing bit not applied");
  a_bw_rate: assert property (
    r_reg.bw != 2'b00 && dec_in_v && $stable(r_reg.bw)
      && !(reg_wr_i && reg_addr_i == sdds_pkg::ADDR_BW) |=> !dec_in_v)
    else $error("sinc decimation not applied");
  // A tick into a full buffer must park its word, never drop it
  a_fifo_full: assert property (tick && r_reg.cnt == 2'd2 |=> r_reg.pend_v)
    else $error("word lost at full buffer");
endmodule
`default_nettype wire

// File: dv/sdds_rx_model.sv
// Receiver model that latches output words on the data clock's valid edge
`timescale 1ns/1ns
`default_nettype none
module sdds_rx_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  // Bench controls
  input  wire logic        stall_i,
  input  wire logic        invert_i,
  // Device outputs and the ready returned to it
  input  wire logic [15:0] data_i,
  input  wire logic        dco_i,
  output logic             ready_o,
  // Captured results
  output int               count_o,
  output logic [15:0]      word_o,
  output int               gap_o,
  output int               pair_o
);
  logic dco_reg;
  int   since;

  // A stalled receiver really holds back, so the buffer fills and the resampler stalls
  always @(posedge core_clk_i) begin
    ready_o <= !stall_i && !reset_i;
    dco_reg <= dco_i;
    if (reset_i) begin
      count_o <= 0;
      since   <= 0;
      gap_o   <= 0;
      pair_o  <= 0;
      word_o  <= 16'h0000;
    end else if (dco_i === !invert_i && dco_reg === invert_i) begin
      word_o  <= data_i;
      count_o <= count_o + 1;
      gap_o   <= since;
      pair_o  <= gap_o + since;
      since   <= 1;
    end else begin
      since <= since + 1;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the decimation and rate converter engine
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int LIMIT = 30000;
  logic        clk = 1'b0;
  logic        reset_i = 1'b1;
  logic        mod_bit_i = 1'b1;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [8:0]  reg_addr_i = 9'h000;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        stall = 1'b0;
  logic        inv = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        out_ready_i;
  logic        word_valid_o;
  logic        data_clock_output;
  logic        swing;
  logic [15:0] data_o;
  logic [15:0] rx_word;
  logic [15:0] w0;
  logic [15:0] e;
  int          rx_count;
  int          rx_gap;
  int          rx_pair;
  int          cycles = 0;
  int          miscompares = 0;
  int          check_count = 0;
  int          held;
  logic [5:0]  codes [6] = '{6'h01, 6'h08, 6'h09, 6'h0a, 6'h11, 6'h3f};

  always #20 clk = ~clk;

  sdds_engine dut (
    .core_clk_i          (clk),
    .reset_i             (reset_i),
    .mod_bit_i           (mod_bit_i),
    .reg_wr_i            (reg_wr_i),
    .reg_rd_i            (reg_rd_i),
    .reg_addr_i          (reg_addr_i),
    .reg_wdata_i         (reg_wdata_i),
    .reg_rdata_o         (reg_rdata_o),
    .out_ready_i         (out_ready_i),
    .word_valid_o        (word_valid_o),
    .data_o              (data_o),
    .data_clock_output_o (data_clock_output),
    .swing_full_o        (swing)
  );

  sdds_rx_model rx (
    .core_clk_i (clk),
    .reset_i    (reset_i),
    .stall_i    (stall),
    .invert_i   (inv),
    .data_i     (data_o),
    .dco_i      (data_clock_output),
    .ready_o    (out_ready_i),
    .count_o    (rx_count),
    .word_o     (rx_word),
    .gap_o      (rx_gap),
    .pair_o     (rx_pair)
  );

  task automatic close_out;
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk);
    #1;
    reg_wr_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(posedge clk);
    #1;
    reg_rd_i = 1'b0;
    chk_val("register read", {8'h00, exp}, {8'h00, reg_rdata_o});
  endtask

  // Bounded wait so a silent converter ends as a mismatch, not a hang
  task automatic wait_words(input int n);
    int start;
    int t;
    start = rx_count;
    t = 0;
    while (rx_count < start + n && t < 400 * n) begin
      @(posedge clk);
      #2;
      t++;
    end
    chk_cnt("words arrived", start + n, rx_count);
  endtask

  // Two successive gaps always sum to twice the factor, half steps included
  task automatic rate(input logic [5:0] code);
    wr(sdds_pkg::ADDR_DIV, 8'h00);
    wr(sdds_pkg::ADDR_DIV, {2'b00, code});
    wait_words(4);
    chk_cnt("two word gaps", (code <= 6'h08) ? 8 : int'(code), rx_pair);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    reset_i = 1'b0;
    chk_val("dco idle", 16'h0001, {15'h0000, data_clock_output});
    chk_val("swing", 16'h0000, {15'h0000, swing});
    chk_val("valid", 16'h0000, {15'h0000, word_valid_o});
    rd_chk(sdds_pkg::ADDR_BW, 8'h00);
    rd_chk(sdds_pkg::ADDR_FMT, 8'h00);
    rd_chk(sdds_pkg::ADDR_DCO, 8'h00);
    rd_chk(sdds_pkg::ADDR_DIV, 8'h08);
    rd_chk(9'h100, 8'h00);
    wait_words(600);
    w0 = rx_word;
    chk_val("positive sign", 16'h0001, {15'h0000, w0[15]});
    wr(sdds_pkg::ADDR_FMT, 8'hff);
    wait_words(3);
    rd_chk(sdds_pkg::ADDR_FMT, 8'h83);
    chk_val("swing", 16'h0001, {15'h0000, swing});
    chk_val("format word", w0, rx_word);
    for (int f = 0; f < 3; f++) begin
      wr(sdds_pkg::ADDR_FMT, 8'(f));
      wait_words(3);
      case (f)
        1: e = w0 ^ 16'h8000;
        2: e = w0 ^ (w0 >> 1);
        default: e = w0;
      endcase
      chk_val("format word", e, rx_word);
    end
    chk_val("swing", 16'h0000, {15'h0000, swing});
    wr(sdds_pkg::ADDR_FMT, 8'h00);
    mod_bit_i = 1'b0;
    wait_words(600);
    chk_val("negative sign", 16'h0000, {15'h0000, rx_word[15]});
    foreach (codes[i]) rate(codes[i]);
    wr(sdds_pkg::ADDR_DIV, 8'h00);
    // A word popped just before the reset may still show its valid edge
    repeat (4) @(posedge clk);
    #2;
    held = rx_count;
    repeat (100) @(posedge clk);
    #2;
    chk_val("valid in reset", 16'h0000, {15'h0000, word_valid_o});
    chk_cnt("words in reset", held, rx_count);
    rate(6'h08);
    stall = 1'b1;
    repeat (60) @(posedge clk);
    #2;
    held = rx_count;
    e = data_o;
    repeat (20) @(posedge clk);
    #2;
    chk_val("valid while stalled", 16'h0001, {15'h0000, word_valid_o});
    chk_val("word held", e, data_o);
    chk_cnt("no capture stalled", held, rx_count);
    stall = 1'b0;
    wait_words(4);
    wr(sdds_pkg::ADDR_DCO, 8'h80);
    inv = 1'b1;
    rd_chk(sdds_pkg::ADDR_DCO, 8'h80);
    rate(6'h0a);
    for (int b = 1; b < 3; b++) begin
      wr(sdds_pkg::ADDR_BW, 8'(b << 5));
      rd_chk(sdds_pkg::ADDR_BW, 8'(b << 5));
      rate(6'h09);
    end
    close_out();
  end
endmodule
`default_nettype wire
